// ==== inc/rpl_defines.svh ====
// Purpose: constants of the pointer and immediate load execution block
// Assumes: 10-bit instruction words, one word per machine cycle
// Notes: opcode fields are matched on the upper bits of the word
//
// Contract
// - increment adds one to low pointer, wraps
// - increment skips next word when result zero
// - prefix 000111 plus n loads accumulator
// - back-to-back accumulator loads: only first runs
// - dual load writes x high, y low pointer
// - dual load: bits 9,8 one, x 7:4, y 3:0
// - back-to-back dual loads: only first runs
// - prefix 00010010 plus z loads bank pointer
`ifndef RPL_DEFINES_SVH
`define RPL_DEFINES_SVH

// low pointer increment occupies one full code point
`define RPL_OP_INC_WORD 10'h013
`define RPL_LA_PREFIX 6'h07
`define RPL_LA_MSB 9
`define RPL_LA_LSB 4
`define RPL_LXY_PREFIX 2'h3
`define RPL_LXY_MSB 9
`define RPL_LXY_LSB 8
`define RPL_LZ_PREFIX 8'h12
`define RPL_LZ_MSB 9
`define RPL_LZ_LSB 2
`define RPL_IMM_HI_MSB 7
`define RPL_IMM_HI_LSB 4
`define RPL_IMM_LO_MSB 3
`define RPL_IMM_LO_LSB 0
`define RPL_NIB_RESET 4'h0
`define RPL_BANK_RESET 2'h0
`define RPL_NIB_ONE 4'h1
`define RPL_NIB_ZERO 4'h0
`define RPL_EXEC_CYCLES 1

`endif

// ==== inc/rpl_pkg.sv ====
// Purpose: shared types of the pointer and immediate load block
// Assumes: nothing beyond the defines header
// Notes: op class none covers every word this block does not execute
package rpl_pkg;

  typedef enum logic [2:0] {
    RPL_OP_NONE,
    RPL_OP_INC,
    RPL_OP_LA,
    RPL_OP_LXY,
    RPL_OP_LZ
  } rpl_op_t;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] ptr_x;
    logic [3:0] ptr_y;
    logic [1:0] bank;
    logic skip_pend;
    rpl_op_t prev_op;
    logic executed;
    logic skipped;
    logic carry_write;
  } rpl_state_t;

endpackage

// ==== inc/rpl_dec_if.sv ====
// Purpose: carries a fetched word to the decoder and its class back
// Assumes: decoder is purely combinational
// Notes: imm_hi and imm_lo are raw word fields, meaning depends on op
`timescale 1ns/1ps
interface rpl_dec_if;
  logic [9:0] word;
  rpl_pkg::rpl_op_t op;
  logic [3:0] imm_hi;
  logic [3:0] imm_lo;

  modport dec
  (
    input word,
    output op,
    output imm_hi,
    output imm_lo
  );

  modport core
  (
    output word,
    input op,
    input imm_hi,
    input imm_lo
  );
endinterface

// ==== src/rpl_decode.sv ====
// Purpose: classifies a 10-bit word into one of the four handled ops or none
// Assumes: word is stable for the whole cycle
// Notes: dual load takes a quarter of the code space, checked last
`timescale 1ns/1ps
`include "rpl_defines.svh"
module rpl_decode
(
  rpl_dec_if.dec bus
);

  function automatic rpl_pkg::rpl_op_t classify(input logic [9:0] w);
    rpl_pkg::rpl_op_t c;
    c = rpl_pkg::RPL_OP_NONE;
    if (w == `RPL_OP_INC_WORD)
      c = rpl_pkg::RPL_OP_INC;
    else if (w[`RPL_LA_MSB:`RPL_LA_LSB] == `RPL_LA_PREFIX)
      c = rpl_pkg::RPL_OP_LA;
    else if (w[`RPL_LZ_MSB:`RPL_LZ_LSB] == `RPL_LZ_PREFIX)
      c = rpl_pkg::RPL_OP_LZ;
    else if (w[`RPL_LXY_MSB:`RPL_LXY_LSB] == `RPL_LXY_PREFIX)
      c = rpl_pkg::RPL_OP_LXY;
    return c;
  endfunction

  always_comb
  begin
    bus.op = classify(bus.word);
    bus.imm_hi = bus.word[`RPL_IMM_HI_MSB:`RPL_IMM_HI_LSB];
    bus.imm_lo = bus.word[`RPL_IMM_LO_MSB:`RPL_IMM_LO_LSB];
  end

endmodule

// ==== src/rpl_core.sv ====
// Purpose: executes pointer increment and the three immediate loads
// Assumes: fetch offers at most one word per clock, same clock domain
// Notes: a skipped word is consumed without changing acc, pointers or bank
`timescale 1ns/1ps
`include "rpl_defines.svh"
module rpl_core
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic instr_valid_i,
  input wire logic [9:0] instr_i,
  output logic [3:0] acc_o,
  output logic [3:0] ptr_x_o,
  output logic [3:0] ptr_y_o,
  output logic [1:0] bank_o,
  output logic skip_pend_o,
  output logic executed_o,
  output logic skipped_o,
  output logic carry_write_o
);

  logic rst_meta;
  logic rst_sync;
  rpl_pkg::rpl_state_t st;
  rpl_pkg::rpl_state_t next_st;
  rpl_dec_if dec_bus();
  logic chain_skip;
  logic [3:0] inc_y;

  // release is synchronised, assertion is immediate
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign dec_bus.word = instr_i;

  rpl_decode rpl_decode_inst
  (
    .bus(dec_bus.dec)
  );

  function automatic logic [3:0] nib_inc(input logic [3:0] v);
    return v + `RPL_NIB_ONE; // 4-bit sum drops the carry, so 15 wraps
  endfunction

  assign inc_y = nib_inc(st.ptr_y);

  // a run of accumulator loads or of dual loads is cut after its first, even if that first
  // was itself skipped by a preceding increment
  assign chain_skip =
    (dec_bus.op == rpl_pkg::RPL_OP_LA && st.prev_op == rpl_pkg::RPL_OP_LA)
    || (dec_bus.op == rpl_pkg::RPL_OP_LXY
        && st.prev_op == rpl_pkg::RPL_OP_LXY);

  always_comb
  begin
    next_st = st;
    next_st.executed = 1'b0;
    next_st.skipped = 1'b0;
    next_st.carry_write = 1'b0;
    if (instr_valid_i)
    begin
      next_st.prev_op = dec_bus.op;
      if (st.skip_pend || chain_skip)
      begin
        next_st.skipped = 1'b1;
        next_st.skip_pend = 1'b0;
      end
      else
      begin
        next_st.executed = 1'b1;
        case (dec_bus.op)
          rpl_pkg::RPL_OP_INC:
          begin
            next_st.ptr_y = inc_y;
            next_st.skip_pend = (inc_y == `RPL_NIB_ZERO);
          end
          rpl_pkg::RPL_OP_LA:
          begin
            next_st.acc = dec_bus.imm_lo;
          end
          rpl_pkg::RPL_OP_LXY:
          begin
            next_st.ptr_x = dec_bus.imm_hi;
            next_st.ptr_y = dec_bus.imm_lo;
          end
          rpl_pkg::RPL_OP_LZ:
          begin
            next_st.bank = dec_bus.imm_lo[1:0];
          end
          default:
          begin
            next_st.skip_pend = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      st.acc <= `RPL_NIB_RESET;
      st.ptr_x <= `RPL_NIB_RESET;
      st.ptr_y <= `RPL_NIB_RESET;
      st.bank <= `RPL_BANK_RESET;
      st.skip_pend <= 1'b0;
      st.prev_op <= rpl_pkg::RPL_OP_NONE;
      st.executed <= 1'b0;
      st.skipped <= 1'b0;
      st.carry_write <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign acc_o = st.acc;
  assign ptr_x_o = st.ptr_x;
  assign ptr_y_o = st.ptr_y;
  assign bank_o = st.bank;
  assign skip_pend_o = st.skip_pend;
  assign executed_o = st.executed;
  assign skipped_o = st.skipped;
  assign carry_write_o = st.carry_write;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_sync);

  sequence s_run(rpl_pkg::rpl_op_t op);
    instr_valid_i && dec_bus.op == op && !st.skip_pend && !chain_skip;
  endsequence

  sequence s_pair(rpl_pkg::rpl_op_t op);
    instr_valid_i && dec_bus.op == op ##1 instr_valid_i && dec_bus.op == op;
  endsequence

  property p_inc_wrap;
    s_run(rpl_pkg::RPL_OP_INC) |=>
      ptr_y_o == 4'($past(ptr_y_o) + 4'h1) && executed_o;
  endproperty
  a_inc_wrap: assert property (p_inc_wrap)
    else $error("low pointer increment wrong");

  // gaps keep the skip armed, so any later offered word is the one cut
  sequence s_pend_taken;
    instr_valid_i && skip_pend_o;
  endsequence

  property p_inc_skip;
    s_pend_taken |=> skipped_o && !executed_o;
  endproperty
  a_inc_skip: assert property (p_inc_skip)
    else $error("word after zero increment not skipped");

  property p_inc_noskip;
    s_run(rpl_pkg::RPL_OP_INC) |=> (ptr_y_o != 4'h0) == !skip_pend_o;
  endproperty
  a_inc_noskip: assert property (p_inc_noskip)
    else $error("skip pending does not match pointer result");

  property p_la_load;
    s_run(rpl_pkg::RPL_OP_LA) |=> acc_o == $past(instr_i[3:0]);
  endproperty
  a_la_load: assert property (p_la_load)
    else $error("accumulator not loaded with immediate");

  property p_la_chain;
    s_pair(rpl_pkg::RPL_OP_LA) |=> skipped_o && $stable(acc_o);
  endproperty
  a_la_chain: assert property (p_la_chain)
    else $error("second accumulator load executed");

  property p_lxy_load;
    s_run(rpl_pkg::RPL_OP_LXY) |=>
      ptr_x_o == $past(instr_i[7:4]) && ptr_y_o == $past(instr_i[3:0]);
  endproperty
  a_lxy_load: assert property (p_lxy_load)
    else $error("dual pointer load wrong");

  property p_lxy_decode;
    instr_valid_i && instr_i[9:8] == 2'h3
      |-> dec_bus.op == rpl_pkg::RPL_OP_LXY;
  endproperty
  a_lxy_decode: assert property (p_lxy_decode)
    else $error("dual pointer load not decoded");

  property p_lxy_chain;
    s_pair(rpl_pkg::RPL_OP_LXY) |=>
      skipped_o && $stable(ptr_x_o) && $stable(ptr_y_o);
  endproperty
  a_lxy_chain: assert property (p_lxy_chain)
    else $error("second dual pointer load executed");

  property p_lz_load;
    s_run(rpl_pkg::RPL_OP_LZ) |=> bank_o == $past(instr_i[1:0]);
  endproperty
  a_lz_load: assert property (p_lz_load)
    else $error("bank pointer not loaded");

  property p_one_cycle;
    instr_valid_i |=> (executed_o ^ skipped_o) && !carry_write_o;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("word not finished in one cycle");

  property p_idle;
    !instr_valid_i |=> !executed_o && !skipped_o && $stable(acc_o)
      && $stable(bank_o);
  endproperty
  a_idle: assert property (p_idle)
    else $error("state changed with no word offered");

endmodule

// ==== verif/ram_pointer_immediate_load_exec_test.sv ====
// Purpose: self-checking bench for the pointer and immediate load core
// Assumes: one word offered per cycle, inputs driven at the falling edge
// Notes: results are sampled at the falling edge after the taking edge
`timescale 1ns/1ps
module ram_pointer_immediate_load_exec_test;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic valid = 1'b0;
  logic [9:0] instr = 10'h000;
  logic [3:0] acc;
  logic [3:0] ptr_x;
  logic [3:0] ptr_y;
  logic [1:0] bank;
  logic skip_pend;
  logic executed;
  logic skipped;
  logic carry_write;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  rpl_core rpl_core_inst
  (
    .clk_i(clk),
    .resetn_i(resetn),
    .instr_valid_i(valid),
    .instr_i(instr),
    .acc_o(acc),
    .ptr_x_o(ptr_x),
    .ptr_y_o(ptr_y),
    .bank_o(bank),
    .skip_pend_o(skip_pend),
    .executed_o(executed),
    .skipped_o(skipped),
    .carry_write_o(carry_write)
  );

  task final_report();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run is well under a few hundred cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      err_count++;
      final_report();
    end
  end

  task chk(input logic [9:0] seen, input logic [9:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // called at a falling edge; valid stays up so words run back to back
  task offer(input logic [9:0] w, input logic ex);
    valid = 1'b1;
    instr = w;
    @(negedge clk);
    chk({executed, skipped}, ex ? 10'h002 : 10'h001);
    chk(carry_write, 10'h000);
  endtask

  task idle();
    valid = 1'b0;
    @(negedge clk);
  endtask

  task test_acc();
    offer(10'h075, 1'b1);
    chk(acc, 10'h005);
    offer(10'h07F, 1'b0);
    chk(acc, 10'h005);
    idle();
    // a gap keeps the chain alive
    offer(10'h07A, 1'b0);
    chk(acc, 10'h005);
    offer(10'h000, 1'b1);
    offer(10'h070, 1'b1);
    chk(acc, 10'h000);
    offer(10'h000, 1'b1);
    offer(10'h07F, 1'b1);
    chk(acc, 10'h00F);
  endtask

  task test_dual();
    offer(10'h3A5, 1'b1);
    chk(ptr_x, 10'h00A);
    chk(ptr_y, 10'h005);
    offer(10'h3FF, 1'b0);
    chk({ptr_x, ptr_y}, 10'h0A5);
    offer(10'h04B, 1'b1);
    chk(bank, 10'h003);
    offer(10'h048, 1'b1);
    chk(bank, 10'h000);
    offer(10'h3C3, 1'b1);
    chk({ptr_x, ptr_y}, 10'h0C3);
    chk(acc, 10'h00F);
  endtask

  task test_inc();
    offer(10'h000, 1'b1);
    offer(10'h33E, 1'b1);
    offer(10'h013, 1'b1);
    chk(ptr_y, 10'h00F);
    chk(skip_pend, 10'h000);
    offer(10'h013, 1'b1);
    chk(ptr_y, 10'h000);
    chk(skip_pend, 10'h001);
    chk(ptr_x, 10'h003);
    offer(10'h079, 1'b0);
    chk(acc, 10'h00F);
    chk(skip_pend, 10'h000);
    offer(10'h013, 1'b1);
    chk(ptr_y, 10'h001);
    offer(10'h30F, 1'b1);
    offer(10'h013, 1'b1);
    chk(ptr_y, 10'h000);
    idle();
    // an idle cycle must not use up the pending skip
    chk(skip_pend, 10'h001);
    offer(10'h049, 1'b0);
    chk(bank, 10'h000);
    idle();
  endtask

  // reset in mid-run clears registers and the chain history
  task test_reset();
    offer(10'h071, 1'b1);
    chk(acc, 10'h001);
    valid = 1'b0;
    resetn = 1'b0;
    @(negedge clk);
    chk({acc, ptr_x, executed, skipped}, 10'h000);
    chk({ptr_y, bank, skip_pend}, 10'h000);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    offer(10'h072, 1'b1);
    chk(acc, 10'h002);
    idle();
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    repeat (3) @(negedge clk);
    chk({acc, ptr_x, executed, skipped}, 10'h000);
    chk({ptr_y, bank, skip_pend}, 10'h000);
    test_acc();
    test_dual();
    test_inc();
    test_reset();
    final_report();
  end
endmodule
